/* hdl/sibw_pkg.sv */
/*
  Shared constants for the indexed block write link:
  a two-wire bus host that sends index, count and data bytes, and a
  target that acknowledges each data byte within the count while its queue has room and stores data at consecutive
  locations. Assumes both ends share one system clock at 250 MHz.
*/
// Functional notes
// RL1: Host opens each transaction with START.
// RL2: Address byte with write bit, acknowledged.
// RL3: Index byte acknowledged, becomes first location.
// RL4: Count byte acknowledged before any data.
// RL5: Host sends exactly count bytes, ascending; the host stops early when d_valid is low.
// RL6: Target acknowledges every data byte separately; the target refuses a byte past the count or when its queue is full.
// RL7: Host ends with STOP after last byte.
// RL8: Store byte at index, then increment.
package sibw_pkg;
  localparam int unsigned SIBW_DW        = 8;
  localparam int unsigned SIBW_FIFO_DEP  = 16;
  localparam logic [6:0]  SIBW_ADDR_DEF  = 7'h5a; // Arbitrary target address
  localparam int unsigned SIBW_CLK_MHZ   = 250;
  localparam int unsigned SIBW_HALF_NS   = 5000;  // Bus clock half period, 100 kHz
  localparam int unsigned SIBW_HALF_CYC  = SIBW_HALF_NS * SIBW_CLK_MHZ / 1000;
  localparam logic [3:0]  SIBW_BIT_LAST  = 4'h7;
endpackage

/* hdl/sibw_if.sv */
/*
  Two-wire link between host and target. Both lines are open drain;
  the wire is low while any party enables its driver.
  Assumes external pull-ups, modelled here as the default high level.
*/
`timescale 1ns/1ps
interface sibw_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl;
  logic sda;
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_t_oe && !sda_t_o));
  modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl, sda);
  modport target (output sda_t_o, sda_t_oe, input scl, sda);
endinterface

/* hdl/sibw_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides and flip-flop storage.
  Assumes a single clock; full and empty derive from an occupancy count.
*/
`timescale 1ns/1ps
module sibw_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clocking
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready && ce;
  assign pop       = out_valid && out_ready && ce;
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* hdl/sibw_target.sv */
/*
  Target end of the indexed block write. Samples the bus clock and data
  through two flip-flops, decodes START and STOP, acknowledges address,
  index, count and each data byte within the count while the queue has room, and queues index/data pairs in a FIFO
  toward the user store port.
  Assumes the host keeps the bus clock at most 100 kHz.
*/
`timescale 1ns/1ps
module sibw_target
  import sibw_pkg::*;
(
  // Clocking
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // Link
  sibw_if.target           link,
  // User store port
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [7:0]       wr_index,
  output logic [7:0]       wr_data,
  output logic             busy
);
  typedef enum {T_IDLE, T_ADDR, T_INDEX, T_COUNT, T_DATA, T_SKIP} sibw_tst_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_p;
    logic       sda_p;
    sibw_tst_t  st;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic       ack_ph;
    logic       ack_drv;
    logic [7:0] idx;
    logic [7:0] left;
    logic       fifo_v;
    logic [15:0] fifo_d;
    logic       busy;
  } sibw_tgt_t;
  sibw_tgt_t s_r, s_nxt;
  logic        f_ready;
  logic        f_ov;
  logic [15:0] f_od;
  logic        scl_rise, scl_fall, start_c, stop_c;

  // ==================================================
  // Data queue toward the store port
  sibw_fifo #(.WIDTH(16), .DEPTH(SIBW_FIFO_DEP)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (s_r.fifo_v),
    .in_ready  (f_ready),
    .in_data   (s_r.fifo_d),
    .out_valid (f_ov),
    .out_ready (wr_ready),
    .out_data  (f_od)
  );
  assign wr_valid = f_ov;
  assign wr_index = f_od[15:8];
  assign wr_data  = f_od[7:0];
  assign busy     = s_r.busy;
  assign link.sda_t_o  = 1'b0;
  assign link.sda_t_oe = s_r.ack_drv;

  // ==================================================
  // Bus decode
  assign scl_rise = s_r.scl_s[1] && !s_r.scl_p;
  assign scl_fall = !s_r.scl_s[1] && s_r.scl_p;
  assign start_c  = s_r.scl_s[1] && s_r.scl_p && s_r.sda_p && !s_r.sda_s[1]; // RL1
  assign stop_c   = s_r.scl_s[1] && s_r.scl_p && !s_r.sda_p && s_r.sda_s[1]; // RL7

  always_comb begin
    s_nxt        = s_r;
    s_nxt.scl_s  = {s_r.scl_s[0], link.scl};
    s_nxt.sda_s  = {s_r.sda_s[0], link.sda};
    s_nxt.scl_p  = s_r.scl_s[1];
    s_nxt.sda_p  = s_r.sda_s[1];
    if (f_ready) begin
      s_nxt.fifo_v = 1'b0;
    end
    if (start_c) begin
      s_nxt.st     = T_ADDR;
      s_nxt.bitc   = '0;
      s_nxt.ack_ph = 1'b0;
      s_nxt.ack_drv = 1'b0;
      s_nxt.busy   = 1'b1;
    end else if (stop_c) begin
      s_nxt.st      = T_IDLE;
      s_nxt.ack_drv = 1'b0;
      s_nxt.busy    = 1'b0;
    end else if (s_r.st != T_IDLE && s_r.st != T_SKIP) begin
      if (scl_rise && !s_r.ack_ph) begin
        s_nxt.sh   = {s_r.sh[6:0], s_r.sda_s[1]};
        s_nxt.bitc = s_r.bitc + 4'h1;
      end
      if (scl_fall && !s_r.ack_ph && s_r.bitc == SIBW_BIT_LAST + 4'h1) begin
        s_nxt.ack_ph = 1'b1;
        s_nxt.bitc   = '0;
        case (s_r.st)
          T_ADDR: begin
            if (s_r.sh == {SIBW_ADDR_DEF, 1'b0}) begin
              s_nxt.ack_drv = 1'b1; // RL2
            end else begin
              s_nxt.st = T_SKIP;
            end
          end
          T_INDEX: begin
            s_nxt.ack_drv = 1'b1; // RL3
            s_nxt.idx     = s_r.sh; // RL3
          end
          T_COUNT: begin
            s_nxt.ack_drv = 1'b1; // RL4
            s_nxt.left    = s_r.sh;
          end
          T_DATA: begin
            // Refuse a byte past the count or when the queue is full
            if (s_r.left != '0 && f_ready && !s_r.fifo_v) begin
              s_nxt.ack_drv = 1'b1; // RL6
              s_nxt.fifo_v  = 1'b1;
              s_nxt.fifo_d  = {s_r.idx, s_r.sh}; // RL8
              s_nxt.idx     = s_r.idx + 8'h01; // RL8
              s_nxt.left    = s_r.left - 8'h01; // RL5
            end
          end
          default: begin
            s_nxt.st = T_SKIP;
          end
        endcase
      end else if (scl_fall && s_r.ack_ph) begin
        s_nxt.ack_ph  = 1'b0;
        s_nxt.ack_drv = 1'b0;
        case (s_r.st)
          T_ADDR:  s_nxt.st = T_INDEX;
          T_INDEX: s_nxt.st = T_COUNT;
          T_COUNT: s_nxt.st = T_DATA;
          T_DATA:  s_nxt.st = s_r.ack_drv ? T_DATA : T_SKIP;
          default: s_nxt.st = T_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r        <= '0;
      s_r.scl_s  <= 2'h3;
      s_r.sda_s  <= 2'h3;
      s_r.scl_p  <= 1'b1;
      s_r.sda_p  <= 1'b1;
      s_r.st     <= T_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
endmodule

/* hdl/sibw_host.sv */
/*
  Host end: on a go pulse drives START, address with write bit, index,
  count, then up to count data bytes taken from a user valid/ready stream while d_valid is high,
  checks each acknowledge and ends with STOP. Bus clock is divided down
  from the system clock. Assumes one transaction at a time.
*/
`timescale 1ns/1ps
module sibw_host
  import sibw_pkg::*;
#(
  // System clock cycles per bus clock half period
  parameter int unsigned HALF_CYC = SIBW_HALF_CYC
) (
  // Clocking
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // Link
  sibw_if.host             link,
  // Command
  input  wire logic        go,
  input  wire logic [7:0]  start_index,
  input  wire logic [7:0]  byte_count,
  // Data stream
  input  wire logic        d_valid,
  output logic             d_ready,
  input  wire logic [7:0]  d_data,
  // Status
  output logic             done,
  output logic             nack_err,
  output logic             busy
);
  typedef enum {H_IDLE, H_START, H_BITS, H_ACK, H_STOP} sibw_hst_t;
  typedef struct packed {
    sibw_hst_t  st;
    logic [15:0] tick;
    logic [1:0] ph;
    logic       scl;
    logic       sda;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic [1:0] phase;
    logic [7:0] cnt;
    logic [7:0] idx;
    logic       ackbit;
    logic       d_ready;
    logic       done;
    logic       nack;
    logic       busy;
    logic [1:0] sda_s;
  } sibw_h_t;
  sibw_h_t h_r, h_nxt;
  logic    step;

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = !h_r.scl;
  assign link.sda_h_o  = 1'b0;
  assign link.sda_h_oe = !h_r.sda;
  assign d_ready  = h_r.d_ready;
  assign done     = h_r.done;
  assign nack_err = h_r.nack;
  assign busy     = h_r.busy;
  // Quarter-period ticks of the bus clock
  assign step = (h_r.tick == 16'(HALF_CYC / 2 - 1));

  always_comb begin
    h_nxt         = h_r;
    h_nxt.done    = 1'b0;
    h_nxt.d_ready = 1'b0;
    h_nxt.sda_s   = {h_r.sda_s[0], link.sda};
    h_nxt.tick    = step ? '0 : h_r.tick + 16'h1;
    if (h_r.st == H_IDLE) begin
      h_nxt.tick = '0;
      if (go) begin
        h_nxt.st    = H_START;
        h_nxt.ph    = '0;
        h_nxt.busy  = 1'b1;
        h_nxt.nack  = 1'b0;
        h_nxt.sh    = {SIBW_ADDR_DEF, 1'b0}; // RL2
        h_nxt.idx   = start_index;
        h_nxt.cnt   = byte_count;
        h_nxt.phase = 2'h0;
      end
    end else if (step) begin
      h_nxt.ph = h_r.ph + 2'h1;
      case (h_r.st)
        H_START: begin
          if (h_r.ph == 2'h1) h_nxt.sda = 1'b0; // RL1
          if (h_r.ph == 2'h3) begin
            h_nxt.scl  = 1'b0;
            h_nxt.st   = H_BITS;
            h_nxt.bitc = '0;
          end
        end
        H_BITS: begin
          if (h_r.ph == 2'h0) h_nxt.sda = h_r.sh[7];
          if (h_r.ph == 2'h1) h_nxt.scl = 1'b1;
          if (h_r.ph == 2'h3) begin
            h_nxt.scl  = 1'b0;
            h_nxt.sh   = {h_r.sh[6:0], 1'b0};
            h_nxt.bitc = h_r.bitc + 4'h1;
            // Release data with the falling clock so the target's ack never meets our low
            if (h_r.bitc == SIBW_BIT_LAST) begin
              h_nxt.st  = H_ACK;
              h_nxt.sda = 1'b1;
            end
          end
        end
        H_ACK: begin
          if (h_r.ph == 2'h0) h_nxt.sda = 1'b1;
          if (h_r.ph == 2'h1) h_nxt.scl = 1'b1;
          if (h_r.ph == 2'h2) h_nxt.ackbit = h_r.sda_s[1];
          if (h_r.ph == 2'h3) begin
            h_nxt.scl  = 1'b0;
            h_nxt.bitc = '0;
            h_nxt.st   = H_BITS;
            if (h_r.ackbit) begin
              h_nxt.nack = 1'b1;
              h_nxt.st   = H_STOP;
            end else if (h_r.phase == 2'h0) begin
              h_nxt.phase = 2'h1;
              h_nxt.sh    = h_r.idx; // RL3
            end else if (h_r.phase == 2'h1) begin
              h_nxt.phase = 2'h2;
              h_nxt.sh    = h_r.cnt; // RL4
            end else if (h_r.cnt != '0 && d_valid) begin
              h_nxt.phase   = 2'h2;
              h_nxt.sh      = d_data; // RL5
              h_nxt.d_ready = 1'b1;
              h_nxt.cnt     = h_r.cnt - 8'h01;
            end else begin
              h_nxt.st = H_STOP; // RL7
            end
          end
        end
        H_STOP: begin
          if (h_r.ph == 2'h0) h_nxt.sda = 1'b0;
          if (h_r.ph == 2'h1) h_nxt.scl = 1'b1;
          if (h_r.ph == 2'h3) begin
            h_nxt.sda  = 1'b1; // RL7
            h_nxt.st   = H_IDLE;
            h_nxt.busy = 1'b0;
            h_nxt.done = 1'b1;
          end
        end
        default: h_nxt.st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      h_r       <= '0;
      h_r.st    <= H_IDLE;
      h_r.scl   <= 1'b1;
      h_r.sda   <= 1'b1;
      h_r.sda_s <= 2'h3;
    end else if (ce) begin
      h_r <= h_nxt;
    end
  end
endmodule

/* test/sibw_link_properties.sv */
/*
  Link checker: watches the resolved two-wire bus and both parties' drivers.
  Assumes it is instantiated beside the interface that joins host and target.
*/
`timescale 1ns/1ps
module sibw_link_checker (
  // Clocking
  input wire logic clock,
  input wire logic rst,
  // Link drivers and resolved wires
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_t_o,
  input wire logic sda_t_oe,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================
  // Frame and bit tracking
  logic       scl_q;
  logic       sda_q;
  logic       in_frame_r;
  logic [3:0] bits_r;
  wire        start_w = scl && scl_q && sda_q && !sda;
  wire        stop_w  = scl && scl_q && !sda_q && sda;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Counts scl rises modulo nine, so 8 marks the ack slot
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      in_frame_r <= 1'b0;
      bits_r     <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_w) begin
        in_frame_r <= 1'b1;
        bits_r     <= 4'h0;
      end else if (stop_w) begin
        in_frame_r <= 1'b0;
      end else if (scl && !scl_q) begin
        bits_r <= (bits_r == 4'h8) ? 4'h0 : bits_r + 4'h1;
      end
    end
  end
  // ==========================================
  // Properties
  sequence s_start;
    scl && sda ##1 scl && !sda;
  endsequence
  sequence s_stop;
    scl && !sda ##1 scl && sda;
  endsequence
  a_idle_bus_released: assert property (!in_frame_r |-> scl && !sda_t_oe)
    else $error("bus not idle outside a frame");
  a_no_repeat_start: assert property (s_start |-> !in_frame_r)
    else $error("start inside a frame");
  a_ack_in_frame: assert property ($rose(sda_t_oe) |-> in_frame_r)
    else $error("ack outside a frame");
  a_ack_pulls_low: assert property (sda_t_oe |-> !sda)
    else $error("ack does not pull data low");
  a_host_yields_ack: assert property (sda_t_oe |-> !(sda_h_oe && !sda_h_o))
    else $error("host drives data during ack");
  a_ack_slot_start: assert property ($rose(sda_t_oe) |-> bits_r == 4'h8 && !scl)
    else $error("ack begins outside its slot");
  a_ack_slot_end: assert property ($fell(sda_t_oe) |-> bits_r == 4'h0 && !scl)
    else $error("ack ends outside its slot");
  a_stop_after_ack: assert property (s_stop |-> bits_r == 4'h1)
    else $error("stop not right after an ack");
endmodule

/* test/smbus_indexed_block_write_tb_top.sv */
/*
  Bench: host and target joined on one link, with a stalled store port run.
  Assumes the design package, interface and modules are compiled first.
*/
`timescale 1ns/1ps
module smbus_indexed_block_write_tb_top
  import sibw_pkg::*;
();
  logic        clock, rst, go, d_valid, wr_ready, stall;
  logic [7:0]  start_index, byte_count, d_data, wr_index, wr_data;
  logic        d_ready, done, nack_err, h_busy, wr_valid, t_busy;
  int          num_errors, samples_checked, seed, n;
  logic [15:0] exp_q[$];
  logic [7:0]  dat[32];
  sibw_if lnk();
  // Fast bus clock here keeps the run short
  sibw_host #(.HALF_CYC(8)) i_sibw_host (.clock(clock), .rst(rst), .ce(1'b1), .link(lnk), .go(go),
    .start_index(start_index),
    .byte_count(byte_count), .d_valid(d_valid), .d_ready(d_ready), .d_data(d_data), .done(done),
    .nack_err(nack_err), .busy(h_busy));
  sibw_target i_sibw_target (.clock(clock), .rst(rst), .ce(1'b1), .link(lnk), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data), .busy(t_busy));
  sibw_link_checker i_sibw_link_checker (.clock(clock), .rst(rst), .scl_o(lnk.scl_o), .scl_oe(lnk.scl_oe),
    .sda_h_o(lnk.sda_h_o), .sda_h_oe(lnk.sda_h_oe), .sda_t_o(lnk.sda_t_o), .sda_t_oe(lnk.sda_t_oe),
    .scl(lnk.scl), .sda(lnk.sda));
  // ==========================================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Sampled at negedge so a one-cycle done pulse is never missed
  task automatic tick_until(input int lim, input bit sel);
    int j;
    for (j = 0; j < lim && !((sel ? done : (exp_q.size() == 0)) === 1'b1); j++)
      @(negedge clock);
    if (j == lim) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic frame(input logic [7:0] si, input logic [7:0] cnt, input logic exp_nack);
    for (int j = 0; j < cnt; j++) begin
      dat[j] = 8'($random(seed));
      // Bytes past the queue depth are refused while the store stalls
      if (j < SIBW_FIFO_DEP) exp_q.push_back({si + 8'(j), dat[j]});
    end
    @(posedge clock);
    n <= 0;
    d_data <= dat[0];
    start_index <= si;
    byte_count <= cnt;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
    // A second go while busy must be ignored
    start_index <= ~si;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    tick_until(60000, 1'b1);
    chk("nack_err", {15'h0, nack_err}, {15'h0, exp_nack});
  endtask
  // ==========================================
  // Stimulus helpers and result watcher
  always @(posedge clock) begin
    if (d_ready === 1'b1) begin
      n <= n + 1;
      d_data <= dat[(n + 1) % 32];
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      chk("store", {wr_index, wr_data}, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    wr_ready <= !stall & 1'($random(seed));
  end
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    seed = 32'h44129c7c;
    {rst, go, d_valid, wr_ready, stall} = 5'h10;
    {start_index, byte_count, d_data} = 24'h0;
    num_errors = 0;
    samples_checked = 0;
    n = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    d_valid <= 1'b1;
    // Index wraps past the top location
    frame(8'hff, 8'h2, 1'b0);
    tick_until(400, 1'b0);
    frame(8'(($random(seed))), 8'h0, 1'b0);
    // Store stalled: queue fills to its depth, next byte is refused
    @(posedge clock);
    stall <= 1'b1;
    frame(8'h10, 8'h11, 1'b1);
    @(negedge clock);
    chk("fill", {15'h0, wr_valid}, 16'h1);
    @(posedge clock);
    stall <= 1'b0;
    tick_until(400, 1'b0);
    @(negedge clock);
    chk("empty", {15'h0, wr_valid}, 16'h0);
    end_sim();
  end
endmodule
